// ### common/odsl_pkg.sv
/*
 * odsl_pkg: constants, field layout, register map and types for the
 * octal converter serial loader.
 * assumes: one 20 MHz bus clock; serial pins arrive asynchronously.
 */
package odsl_pkg;

	// ----------------------------------------------------------------
	// channel and frame geometry
	// ----------------------------------------------------------------
	localparam int ODSL_NUM_CH = 8;
	localparam int ODSL_CODE_W = 10;
	localparam int ODSL_FRAME_W = 16;
	localparam int ODSL_CNT_W = 6;
	localparam logic [5:0] ODSL_CNT_MAX = 6'h3f;
	// edges that must be captured before a frame is executed
	localparam logic [5:0] ODSL_EXEC_MIN = 6'h0f;
	// edges already captured when the serial output is driven high
	localparam logic [5:0] ODSL_DOUT_MARK = 6'h0e;

	// ----------------------------------------------------------------
	// frame fields
	// ----------------------------------------------------------------
	localparam int ODSL_CMD_MSB = 15;
	localparam int ODSL_CMD_LSB = 12;
	localparam int ODSL_CH_MSB = 14;
	localparam int ODSL_CH_LSB = 12;
	localparam int ODSL_CODE_MSB = 11;
	localparam int ODSL_CODE_LSB = 2;
	localparam logic [3:0] ODSL_CMD_REG_ONLY = 4'h8;
	localparam logic [3:0] ODSL_CMD_WRITE_THROUGH = 4'h9;

	// ----------------------------------------------------------------
	// pin synchroniser: {sclk, sync_n, din}, frame sync idles high
	// ----------------------------------------------------------------
	localparam logic [2:0] ODSL_PIN_RST = 3'h2;

	// ----------------------------------------------------------------
	// register map, byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ODSL_ADDR_CTRL = 8'h00;
	localparam logic [7:0] ODSL_ADDR_STATUS = 8'h04;
	localparam logic [7:0] ODSL_ADDR_LAST_FRAME = 8'h08;
	localparam logic [7:0] ODSL_ADDR_COUNTS = 8'h0c;
	localparam logic [2:0] ODSL_PAGE_CHAN_REG = 3'h2;
	localparam logic [2:0] ODSL_PAGE_CHAN_OUT = 3'h3;
	localparam int ODSL_CTRL_LINK_EN_BIT = 0;
	localparam int ODSL_CTRL_LOAD_ALL_BIT = 1;
	localparam logic ODSL_LINK_EN_RST = 1'b1;
	localparam int ODSL_ST_WT_BIT = 0;
	localparam int ODSL_ST_ACTIVE_BIT = 1;
	localparam int ODSL_ST_CNT_LSB = 8;
	localparam logic [2:0] ODSL_HSIZE_WORD = 3'h2;

	typedef enum logic [0:0] {
		ODSL_IDLE,
		ODSL_SHIFT
	} odsl_state_e;

	typedef enum logic [1:0] {
		ODSL_CMD_NONE,
		ODSL_CMD_CHAN,
		ODSL_CMD_MODE_RO,
		ODSL_CMD_MODE_WT
	} odsl_cmd_e;

endpackage : odsl_pkg

// ### hw/odsl_sync2.sv
/*
 * odsl_sync2: two-stage synchroniser for asynchronous pin levels.
 * assumes: inputs are slow levels; only the second stage is read outside.
 */
`timescale 1ns/1ps
module odsl_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input logic clk,
	input logic rst_n,
	input logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : odsl_sync2

// ### hw/odsl_top.sv
/*
 * odsl_top: serial front end of an eight channel 10-bit converter with
 * an AHB-Lite register slave for control, status and readback.
 * assumes: serial clock far slower than hclk (several hclk per half
 * period); a single AHB-Lite master with this slave as the only one.
 */
`timescale 1ns/1ps
// Contract
// RULE1 - a full frame is sixteen serial clock falling edges with frame sync low
// RULE2 - frame sync going low starts a write and opens data capture
// RULE3 - each falling edge while sync low shifts data into sixteen-bit register
// RULE4 - last frame bit is captured on the sixteenth falling edge
// RULE5 - sync rising after a full frame executes the decoded command
// RULE6 - host raises sync between the sixteenth and seventeenth falling edges
// RULE7 - sync rising before the fifteenth edge aborts and discards the frame
// RULE8 - sync held low past seventeen edges passes input data to output
// RULE9 - host never lowers sync on a serial clock falling edge
// RULE10 - host keeps sync high a minimum time between frames
// RULE11 - eight channels, each with its own register feeding a 10-bit converter
// RULE12 - write-through updates output at once, register-only leaves it unchanged
// RULE13 - codes are straight unsigned binary from 0 to 1023
// RULE14 - host should idle serial data low between frames
// RULE15 - host should idle sync high to avoid pass-through output
// RULE16 - top bit zero, next three select channel, code in bits eleven to two
// RULE17 - nibble 1001 selects write-through, 1000 register-only; mode persists
// RULE18 - reset gives register-only mode and all outputs at zero code
// RULE19 - output low for fourteen edges, high on fifteenth, then input stream
// RULE20 - frame bits arrive most significant first
// RULE21 - decode only after fifteen or more edges, ignore shorter frames
module odsl_top
	import odsl_pkg::*;
(
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input logic sclk,
	input logic sync_n,
	input logic din,
	output logic dout,
	output logic [79:0] dac_codes
);
	// ----------------------------------------------------------------
	// pin sampling and edge finding
	// ----------------------------------------------------------------
	logic [2:0] pins_s;
	logic sclk_s;
	logic sync_s;
	logic din_s;
	logic sclk_prev_q;
	logic sync_prev_q;
	logic sclk_fall;
	logic sync_fall;
	logic sync_rise;

	odsl_sync2 #(
		.W(3),
		.RST_VAL(ODSL_PIN_RST)
	) u_pin_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.d({sclk, sync_n, din}),
		.q(pins_s)
	);

	assign sclk_s = pins_s[2];
	assign sync_s = pins_s[1];
	assign din_s = pins_s[0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_prev_q <= 1'b0;
			sync_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			sync_prev_q <= sync_s;
		end
	end

	assign sclk_fall = sclk_prev_q & ~sclk_s;
	assign sync_fall = sync_prev_q & ~sync_s;
	assign sync_rise = ~sync_prev_q & sync_s;

	// ----------------------------------------------------------------
	// frame state
	// ----------------------------------------------------------------
	odsl_state_e state_q;
	logic link_en_q;
	logic [15:0] shift_q;
	logic [5:0] cnt_q;
	logic dout_q;
	logic wt_q;
	logic [15:0] last_frame_q;
	logic [15:0] exec_cnt_q;
	logic [15:0] abort_cnt_q;
	logic [7:0][9:0] chan_reg_q;
	logic [7:0][9:0] out_q;
	logic shifting;
	logic take_bit;
	logic exec_now;
	logic abort_now;
	logic load_all_now;
	odsl_cmd_e cmd;

	function automatic odsl_cmd_e odsl_decode(input logic [15:0] frame);
		logic [3:0] nib;
		nib = frame[ODSL_CMD_MSB:ODSL_CMD_LSB];
		if (!frame[ODSL_CMD_MSB]) begin
			odsl_decode = ODSL_CMD_CHAN;
		end else if (nib == ODSL_CMD_WRITE_THROUGH) begin
			odsl_decode = ODSL_CMD_MODE_WT;
		end else if (nib == ODSL_CMD_REG_ONLY) begin
			odsl_decode = ODSL_CMD_MODE_RO;
		end else begin
			odsl_decode = ODSL_CMD_NONE;
		end
	endfunction : odsl_decode

	assign shifting = (state_q == ODSL_SHIFT);
	// a falling edge seen together with the closing sync edge is not a bit
	assign take_bit = shifting & sclk_fall & ~sync_rise; // [RULE3]
	assign exec_now = shifting & sync_rise & (cnt_q >= ODSL_EXEC_MIN); // [RULE5] [RULE21]
	assign abort_now = shifting & sync_rise & (cnt_q < ODSL_EXEC_MIN); // [RULE7]
	assign cmd = odsl_decode(shift_q); // [RULE16] [RULE17]

	// host keeps sync away from falling edges, so the first edge after
	// the start is a clean first bit [RULE9]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ODSL_IDLE;
		end else begin
			case (state_q)
				ODSL_IDLE: begin
					if (sync_fall && link_en_q) begin
						state_q <= ODSL_SHIFT; // [RULE2]
					end
				end
				ODSL_SHIFT: begin
					if (sync_rise) begin
						state_q <= ODSL_IDLE;
					end
				end
				default: begin
					state_q <= ODSL_IDLE;
				end
			endcase
		end
	end

	// msb first: the first bit ends in bit 15 after sixteen edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= 16'h0000;
			cnt_q <= 6'h00;
		end else if (!shifting && sync_fall) begin
			shift_q <= 16'h0000;
			cnt_q <= 6'h00;
		end else if (take_bit) begin
			shift_q <= {shift_q[14:0], din_s}; // [RULE3] [RULE20]
			if (cnt_q != ODSL_CNT_MAX) begin
				cnt_q <= cnt_q + 6'h01; // [RULE1] [RULE4]
			end
		end else if (abort_now) begin
			shift_q <= 16'h0000; // [RULE7]
		end
	end

	// the delayed stream is the bit taken fifteen edges earlier
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout_q <= 1'b0;
		end else if (take_bit) begin
			if (cnt_q < ODSL_DOUT_MARK) begin
				dout_q <= 1'b0; // [RULE19]
			end else if (cnt_q == ODSL_DOUT_MARK) begin
				dout_q <= 1'b1; // [RULE19]
			end else begin
				dout_q <= shift_q[14]; // [RULE8] [RULE19]
			end
		end else if (!shifting) begin
			dout_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wt_q <= 1'b0; // [RULE18]
		end else if (exec_now && cmd == ODSL_CMD_MODE_WT) begin
			wt_q <= 1'b1; // [RULE17]
		end else if (exec_now && cmd == ODSL_CMD_MODE_RO) begin
			wt_q <= 1'b0; // [RULE17]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_frame_q <= 16'h0000;
			exec_cnt_q <= 16'h0000;
			abort_cnt_q <= 16'h0000;
		end else if (exec_now) begin
			last_frame_q <= shift_q;
			exec_cnt_q <= exec_cnt_q + 16'h0001;
		end else if (abort_now) begin
			abort_cnt_q <= abort_cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// channel registers and converter codes
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ODSL_NUM_CH; g++) begin : g_chan
			logic hit;
			assign hit = exec_now && (cmd == ODSL_CMD_CHAN) &&
				(shift_q[ODSL_CH_MSB:ODSL_CH_LSB] == 3'(g)); // [RULE16]

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					chan_reg_q[g] <= 10'h000;
				end else if (hit) begin
					chan_reg_q[g] <= shift_q[ODSL_CODE_MSB:ODSL_CODE_LSB]; // [RULE11]
				end
			end

			// in write-through mode frame data wins over a bulk load for the same channel
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					out_q[g] <= 10'h000; // [RULE18]
				end else if (hit && wt_q) begin
					out_q[g] <= shift_q[ODSL_CODE_MSB:ODSL_CODE_LSB]; // [RULE12]
				end else if (load_all_now) begin
					out_q[g] <= chan_reg_q[g]; // [RULE12]
				end
			end
		end
	endgenerate

	// unsigned binary code straight to the converter, no offset [RULE13]
	assign dac_codes = out_q;
	assign dout = dout_q;

	// ----------------------------------------------------------------
	// AHB-Lite slave, one wait state on every transfer
	// ----------------------------------------------------------------
	logic acc;
	logic pend_q;
	logic pend_write_q;
	logic pend_ok_q;
	logic [7:0] pend_addr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic hresp_q;
	logic [31:0] rd_val;
	logic ctrl_wr;

	assign acc = hsel & htrans[1] & hready;

	// the wait state lets a read see a write of the transfer before it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 1'b0;
			pend_write_q <= 1'b0;
			pend_ok_q <= 1'b0;
			pend_addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			pend_q <= acc;
			hresp_q <= 1'b0;
			if (acc) begin
				pend_write_q <= hwrite;
				pend_addr_q <= haddr[7:0];
				pend_ok_q <= (hsize == ODSL_HSIZE_WORD) && (haddr[31:8] == 24'h000000) &&
					(haddr[1:0] == 2'h0);
				hreadyout_q <= 1'b0;
			end else if (pend_q) begin
				hreadyout_q <= 1'b1;
			end
		end
	end

	assign ctrl_wr = pend_q & pend_write_q & pend_ok_q & (pend_addr_q == ODSL_ADDR_CTRL);
	assign load_all_now = ctrl_wr & hwdata[ODSL_CTRL_LOAD_ALL_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_en_q <= ODSL_LINK_EN_RST;
		end else if (ctrl_wr) begin
			link_en_q <= hwdata[ODSL_CTRL_LINK_EN_BIT];
		end
	end

	always_comb begin
		rd_val = 32'h00000000;
		if (pend_addr_q[7:5] == ODSL_PAGE_CHAN_REG) begin
			rd_val[9:0] = chan_reg_q[pend_addr_q[4:2]];
		end else if (pend_addr_q[7:5] == ODSL_PAGE_CHAN_OUT) begin
			rd_val[9:0] = out_q[pend_addr_q[4:2]];
		end else begin
			case (pend_addr_q)
				ODSL_ADDR_CTRL: rd_val[ODSL_CTRL_LINK_EN_BIT] = link_en_q;
				ODSL_ADDR_STATUS: begin
					rd_val[ODSL_ST_WT_BIT] = wt_q;
					rd_val[ODSL_ST_ACTIVE_BIT] = shifting;
					rd_val[ODSL_ST_CNT_LSB +: ODSL_CNT_W] = cnt_q;
				end
				ODSL_ADDR_LAST_FRAME: rd_val[15:0] = last_frame_q;
				ODSL_ADDR_COUNTS: rd_val = {abort_cnt_q, exec_cnt_q};
				default: rd_val = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (pend_q && !pend_write_q) begin
			hrdata_q <= pend_ok_q ? rd_val : 32'h00000000;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_bus_wait;
		!hreadyout_q ##1 hreadyout_q;
	endsequence

	sequence s_frame_open;
		!shifting && sync_fall && link_en_q;
	endsequence

	frame_start_a: assert property (s_frame_open |=> shifting && cnt_q == 6'h00) // [RULE2]
		else $error("frame did not open on sync fall");
	bit_shift_a: assert property (take_bit |=> // [RULE3]
		shift_q == {$past(shift_q[14:0]), $past(din_s)})
		else $error("serial bit not shifted in msb first");
	edge_count_a: assert property (take_bit && cnt_q != ODSL_CNT_MAX |=> // [RULE4]
		cnt_q == $past(cnt_q) + 6'h01)
		else $error("falling edge not counted");
	short_abort_a: assert property (abort_now |=> // [RULE7]
		$stable(chan_reg_q) && $stable(wt_q) && abort_cnt_q == $past(abort_cnt_q) + 16'h0001)
		else $error("short frame was not discarded");
	exec_gate_a: assert property ($changed(last_frame_q) || $changed(exec_cnt_q) |-> // [RULE21]
		$past(shifting && sync_rise && cnt_q >= 6'h0f))
		else $error("frame executed without fifteen edges");
	chan_write_a: assert property (exec_now && cmd == ODSL_CMD_CHAN |=> // [RULE16]
		chan_reg_q[$past(shift_q[14:12])] == $past(shift_q[11:2]))
		else $error("channel register not loaded from frame");
	reg_only_a: assert property (exec_now && cmd == ODSL_CMD_CHAN && !wt_q && // [RULE12]
		!load_all_now |=> $stable(out_q))
		else $error("output moved in register-only mode");
	thru_write_a: assert property (exec_now && cmd == ODSL_CMD_CHAN && wt_q |=> // [RULE12]
		out_q[$past(shift_q[14:12])] == $past(shift_q[11:2]))
		else $error("output not updated in write-through mode");
	mode_select_a: assert property (exec_now && // [RULE17]
		cmd inside {ODSL_CMD_MODE_WT, ODSL_CMD_MODE_RO} |=> wt_q == ($past(cmd) == ODSL_CMD_MODE_WT))
		else $error("write mode not taken from command nibble");
	out_cause_a: assert property ($changed(out_q) |-> // [RULE12]
		$past(load_all_now || (exec_now && wt_q && cmd == ODSL_CMD_CHAN)))
		else $error("converter code changed without a valid write");
	dout_mark_a: assert property (take_bit && cnt_q <= ODSL_DOUT_MARK |=> // [RULE19]
		dout_q == ($past(cnt_q) == 6'h0e))
		else $error("serial output preamble wrong");
	dout_pass_a: assert property (take_bit && cnt_q > ODSL_DOUT_MARK |=> // [RULE8]
		dout_q == $past(shift_q[14]))
		else $error("pass-through bit wrong");
	bus_answer_a: assert property (acc |=> s_bus_wait)
		else $error("bus answer not after one wait state");

endmodule : odsl_top

// ### verification/odsl_host_model.sv
/*
 * odsl_host_model: serial host that drives frame sync, serial clock and data.
 * assumes: stepped on hclk; four hclk make one half period of 200 ns.
 */
`timescale 1ns/1ps
module odsl_host_model
	import odsl_pkg::*;
(
	input wire logic hclk,
	output logic sclk,
	output logic sync_n,
	output logic din,
	input wire logic dout
);
	// ------------------------------------------------------------
	// idle levels and frame driver
	// ------------------------------------------------------------
	logic [31:0] dout_log;

	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		din = 1'b0;
		dout_log = '0;
	end

	task automatic half(input int n);
		repeat (4 * n) @(posedge hclk);
	endtask : half

	// sync falls while sclk is high, never on a falling edge; lead stretches the setup
	task automatic frame(input logic [31:0] bits, input int n, input int lead);
		int k;
		sync_n <= 1'b0;
		half(lead);
		for (k = 0; k < n; k++) begin
			din <= bits[n-1-k];
			half(1);
			dout_log[k] = dout;
			sclk <= 1'b0;
			half(1);
			if (k < n - 1) begin
				sclk <= 1'b1;
			end
		end
		// clock stays low until sync is back up, so no extra edge is made
		sync_n <= 1'b1;
		din <= 1'b0;
		half(1);
		sclk <= 1'b1;
		half(2);
	endtask : frame
endmodule : odsl_host_model

// ### verification/odsl_top_test.sv
/*
 * odsl_top_test: register reads over AHB-Lite and serial frames from the host model.
 * assumes: hready is this slave's hreadyout; 20 MHz hclk, 400 ns serial clock.
 */
`timescale 1ns/1ps
module odsl_top_test
	import odsl_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic sclk, sync_n, din, dout;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [79:0] dac_codes;
	logic [9:0] regs [8];
	logic [9:0] codes [8];
	logic [31:0] s;
	int fail_count, checks, cyc, exp_exec, exp_abort, i;
	localparam logic [31:0] CTRL = {24'h0, ODSL_ADDR_CTRL};
	localparam logic [31:0] STAT = {24'h0, ODSL_ADDR_STATUS};

	assign hready = hreadyout;

	odsl_top i_odsl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclk(sclk),
		.sync_n(sync_n), .din(din), .dout(dout), .dac_codes(dac_codes));
	odsl_host_model i_odsl_host_model (.hclk(hclk), .sclk(sclk), .sync_n(sync_n),
		.din(din), .dout(dout));

	// ------------------------------------------------------------
	// clock, timeout and closing
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task end_sim;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// the whole run needs well under 8000 cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			$display("timeout waiting for the design");
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// address phase held until hready, then data phase until hready again
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= ODSL_HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("response", {31'h0, hresp}, 32'h0);
	endtask : bus

	task rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask : rchk

	function automatic logic [31:0] chf(input logic [2:0] ch, input logic [9:0] code);
		return {16'h0, 1'b0, ch, code, 2'h3};
	endfunction : chf

	function automatic logic [31:0] cha(input logic [2:0] page, input int ch);
		return {24'h0, page, ch[2:0], 2'h0};
	endfunction : cha

	task tx(input logic [31:0] b, input int n);
		i_odsl_host_model.frame(b, n, 2);
		if (n >= 15) begin
			exp_exec++;
		end else begin
			exp_abort++;
		end
	endtask : tx

	// registers, readback outputs and the converter codes of all channels
	task all_chk;
		int n;
		for (n = 0; n < 8; n++) begin
			rchk("channel register", cha(ODSL_PAGE_CHAN_REG, n), {22'h0, regs[n]});
			rchk("channel output", cha(ODSL_PAGE_CHAN_OUT, n), {22'h0, codes[n]});
			chk("converter code", {22'h0, dac_codes[10*n +: 10]}, {22'h0, codes[n]});
		end
	endtask : all_chk

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = ODSL_HSIZE_WORD;
		hwdata = 32'h0;
		fail_count = 0;
		checks = 0;
		cyc = 0;
		exp_exec = 0;
		exp_abort = 0;
		for (i = 0; i < 8; i++) begin
			regs[i] = 10'h0;
			codes[i] = 10'h0;
		end
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, STAT, 32'h0);
		chk("mode after reset", rd & 32'h3, 32'h0);
		rchk("control", CTRL, 32'h1);
		all_chk();
		$display("test reset done");
		// register-only writes leave outputs alone; the ignored low bits are ones
		for (i = 0; i < 8; i++) begin
			regs[i] = 10'(i * 146 + 1);
			tx(chf(i[2:0], regs[i]), 16);
		end
		all_chk();
		bus(1'b1, CTRL, 32'h3);
		codes = regs;
		all_chk();
		rchk("control", CTRL, 32'h1);
		$display("test register-only done");
		tx(32'h9000, 16);
		bus(1'b0, STAT, 32'h0);
		chk("write-through mode", rd & 32'h1, 32'h1);
		regs[2] = 10'h0;
		codes[2] = 10'h0;
		tx(chf(3'h2, 10'h0), 16);
		regs[5] = 10'h3ff;
		codes[5] = 10'h3ff;
		tx(chf(3'h5, 10'h3ff), 16);
		all_chk();
		$display("test write-through done");
		tx(chf(3'h0, 10'h2aa) >> 2, 14);
		all_chk();
		tx(32'h0, 15);
		rchk("frame counts", {24'h0, ODSL_ADDR_COUNTS}, {exp_abort[15:0], exp_exec[15:0]});
		// an unused command nibble executes but touches neither mode nor channels
		tx(32'hac3f, 16);
		rchk("last frame", {24'h0, ODSL_ADDR_LAST_FRAME}, 32'hac3f);
		tx(32'h9000, 16);
		regs[0] = 10'h2aa;
		codes[0] = 10'h2aa;
		tx(chf(3'h0, 10'h2aa), 16);
		$display("test short frames done");
		s = {16'ha5c3, 16'h0000} | chf(3'h7, 10'h155);
		tx(s, 32);
		for (i = 1; i < 32; i++) begin
			chk("serial output", {31'h0, i_odsl_host_model.dout_log[i]},
				{31'h0, (i < 15) ? 1'b0 : (i == 15) ? 1'b1 : s[47-i]});
		end
		regs[7] = 10'h155;
		codes[7] = 10'h155;
		rchk("status", STAT, 32'h0000_2001);
		all_chk();
		$display("test long frame done");
		tx(32'h8000, 16);
		regs[1] = 10'h0f0;
		tx(chf(3'h1, 10'h0f0), 16);
		all_chk();
		$display("test back to register-only done");
		bus(1'b1, 32'h100, 32'hffff_ffff);
		rchk("unmapped", 32'h100, 32'h0);
		rchk("unmapped", 32'h10, 32'h0);
		bus(1'b1, CTRL, 32'h0);
		rchk("control", CTRL, 32'h0);
		i_odsl_host_model.frame(chf(3'h3, 10'h077), 16, 4);
		all_chk();
		$display("test bus and link disable done");
		end_sim();
	end
endmodule : odsl_top_test
